// [logic/scm_menu.sv]
`timescale 1ns/1ps
module scm_menu #(
  parameter int unsigned RESTORE_CYCLES = scm_pkg::RESTORE_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             irq_o,
  input  wire logic        factory_restore_n_i,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             menu_active_o
);
  scm_pkg::scm_state_t state_reg;
  scm_pkg::scm_state_t state_next;
  logic [5:0]  msg_ptr_reg;
  logic [5:0]  msg_ptr_next;
  logic [5:0]  msg_end_reg;
  logic [5:0]  msg_end_next;
  logic        strap_done_reg;
  logic [31:0] hold_cnt_reg;
  logic [15:0] div_reg;
  logic [7:0]  esc_reg;
  logic [2:0]  mode_reg;
  logic        role_reg;
  logic [7:0]  line_mem [12];
  logic [3:0]  line_cnt_reg;
  logic [2:0]  sel_reg;
  logic [scm_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [scm_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [scm_pkg::IRQ_W-1:0] irq_events;

  // message text; overflow falls through into retry, banner into prompt
  localparam logic [8*scm_pkg::MSG_LEN-1:0] MSG_ROM = {
    "Overflow buffer", scm_pkg::CH_CR, scm_pkg::CH_LF,
    "Retry >",
    scm_pkg::CH_CR, scm_pkg::CH_LF, "TOP MENU", scm_pkg::CH_CR, scm_pkg::CH_LF,
    "t: top", scm_pkg::CH_CR, scm_pkg::CH_LF,
    "Select(0 ~ 6) >"
  };

  logic        tx_ready;
  logic        tx_valid;
  logic [7:0]  tx_byte;
  logic [7:0]  rx_byte;
  logic        rx_valid;

  // serial engine reloads from the live divisor at each bit, so a restore retimes it from the next bit on
  scm_uart u_uart (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .div_i      (div_reg),
    .tx_data_i  (tx_byte),
    .tx_valid_i (tx_valid),
    .tx_ready_o (tx_ready),
    .tx_o       (txd_o),
    .rx_i       (rxd_i),
    .rx_data_o  (rx_byte),
    .rx_valid_o (rx_valid)
  );

  // message streaming
  assign tx_valid = (state_reg == scm_pkg::ST_SEND);
  assign tx_byte  = MSG_ROM[8*(scm_pkg::MSG_LEN-1-int'(msg_ptr_reg)) +: 8];
  wire   tx_fire  = tx_valid && tx_ready;
  wire   msg_last = tx_fire && (msg_ptr_reg == msg_end_reg);

  // factory restore hold detect, input is active low
  wire hold_low   = !factory_restore_n_i;
  wire restore_ev = hold_low && (hold_cnt_reg == RESTORE_CYCLES - 1);
  wire strap_menu = !strap_done_reg && hold_low;

  // keystroke classification; bytes arriving while a message is sent are dropped
  wire rx_take   = rx_valid && (state_reg == scm_pkg::ST_WAIT);
  wire is_top    = (rx_byte == scm_pkg::CH_TOP);
  wire is_bs     = (rx_byte == scm_pkg::CH_BS) || (rx_byte == scm_pkg::CH_DEL);
  wire is_cr     = (rx_byte == scm_pkg::CH_CR);
  wire digit_ok  = (line_cnt_reg == 4'h1) && (line_mem[0] >= scm_pkg::CH_ZERO)
                   && (line_mem[0] <= scm_pkg::CH_LAST);
  wire ev_top    = rx_take && is_top;
  wire ev_bs     = rx_take && !is_top && is_bs;
  wire ev_sel    = rx_take && !is_top && is_cr && digit_ok;
  wire ev_retry  = rx_take && !is_top && is_cr && !digit_ok;
  wire plain_ch  = rx_take && !is_top && !is_bs && !is_cr;
  wire ev_ovf    = plain_ch && (line_cnt_reg == scm_pkg::LINE_MAX);
  wire ev_store  = plain_ch && (line_cnt_reg != scm_pkg::LINE_MAX);
  wire line_clr  = ev_top || ev_sel || ev_retry || ev_ovf || restore_ev;

  assign irq_events = {restore_ev, ev_ovf, ev_retry, ev_sel};

  // menu sequencing
  always_comb begin
    state_next   = state_reg;
    msg_ptr_next = msg_ptr_reg;
    msg_end_next = msg_end_reg;
    case (state_reg)
      scm_pkg::ST_OFF: begin
        if (strap_menu) begin
          state_next   = scm_pkg::ST_SEND;
          msg_ptr_next = scm_pkg::MSG_TOP;
          msg_end_next = scm_pkg::MSG_END;
        end
      end
      scm_pkg::ST_SEND: begin
        if (restore_ev) begin
          msg_ptr_next = scm_pkg::MSG_TOP;
          msg_end_next = scm_pkg::MSG_END;
        end else if (msg_last) begin
          state_next = scm_pkg::ST_WAIT;
        end else if (tx_fire) begin
          msg_ptr_next = msg_ptr_reg + 6'h01;
        end
      end
      scm_pkg::ST_WAIT: begin
        if (restore_ev || ev_top) begin
          state_next   = scm_pkg::ST_SEND;
          msg_ptr_next = scm_pkg::MSG_TOP;
          msg_end_next = scm_pkg::MSG_END;
        end else if (ev_sel) begin
          state_next   = scm_pkg::ST_SEND;
          msg_ptr_next = scm_pkg::MSG_PROMPT;
          msg_end_next = scm_pkg::MSG_END;
        end else if (ev_retry) begin
          state_next   = scm_pkg::ST_SEND;
          msg_ptr_next = scm_pkg::MSG_RETRY;
          msg_end_next = scm_pkg::MSG_RETRY_END;
        end else if (ev_ovf) begin
          state_next   = scm_pkg::ST_SEND;
          msg_ptr_next = scm_pkg::MSG_OVF;
          msg_end_next = scm_pkg::MSG_RETRY_END;
        end
      end
      default: begin
        state_next = scm_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg     <= scm_pkg::ST_OFF;
      msg_ptr_reg   <= scm_pkg::MSG_TOP;
      msg_end_reg   <= scm_pkg::MSG_END;
      menu_active_o <= 1'b0;
    end else begin
      state_reg     <= state_next;
      msg_ptr_reg   <= msg_ptr_next;
      msg_end_reg   <= msg_end_next;
      menu_active_o <= (state_next != scm_pkg::ST_OFF);
    end
  end

  // strap caught on the first edge after reset release, never under reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_done_reg <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
    end
  end

  // hold counter saturates so one long press restores only once
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_cnt_reg <= 32'h0000_0000;
    end else if (!hold_low) begin
      hold_cnt_reg <= 32'h0000_0000;
    end else if (hold_cnt_reg != RESTORE_CYCLES) begin
      hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
    end
  end

  // pending line; only the count and slots below it matter
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_cnt_reg <= 4'h0;
    end else if (line_clr) begin
      line_cnt_reg <= 4'h0;
    end else if (ev_bs && line_cnt_reg != 4'h0) begin
      line_cnt_reg <= line_cnt_reg - 4'h1;
    end else if (ev_store) begin
      line_cnt_reg <= line_cnt_reg + 4'h1;
    end
  end

  // storage array without reset; contents are qualified by the count
  always_ff @(posedge ref_clk_i) begin
    if (ev_store) begin
      line_mem[line_cnt_reg] <= rx_byte;
    end
  end

  // last accepted top item
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_reg <= 3'h0;
    end else if (ev_sel) begin
      sel_reg <= 3'(line_mem[0] - scm_pkg::CH_ZERO);
    end
  end

  // register decode
  wire wr_div  = wr_i && (addr_i == scm_pkg::ADDR_UART_DIV);
  wire wr_link = wr_i && (addr_i == scm_pkg::ADDR_LINK_CFG);
  wire wr_ist  = wr_i && (addr_i == scm_pkg::ADDR_IRQ_ST);
  wire wr_imsk = wr_i && (addr_i == scm_pkg::ADDR_IRQ_MASK);
  wire [31:0] link_rd = 32'({role_reg, 1'b0, mode_reg, esc_reg});
  wire [31:0] mst_rd  = 32'({sel_reg, line_cnt_reg, 3'h0, menu_active_o});
  logic [31:0] rd_mux;
  always_comb begin
    if (addr_i == scm_pkg::ADDR_UART_DIV) begin
      rd_mux = 32'(div_reg);
    end else if (addr_i == scm_pkg::ADDR_LINK_CFG) begin
      rd_mux = link_rd;
    end else if (addr_i == scm_pkg::ADDR_MENU_ST) begin
      rd_mux = mst_rd;
    end else if (addr_i == scm_pkg::ADDR_IRQ_ST) begin
      rd_mux = 32'(irq_stat_reg);
    end else if (addr_i == scm_pkg::ADDR_IRQ_MASK) begin
      rd_mux = 32'(irq_mask_reg);
    end else begin
      rd_mux = 32'h0000_0000;   // unmapped reads as zero
    end
  end

  // configuration; a restore outranks a software write in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg  <= scm_pkg::DIV_DEFAULT;
      esc_reg  <= scm_pkg::ESC_DEFAULT;
      mode_reg <= scm_pkg::command_driven_link_mode;
      role_reg <= scm_pkg::ROLE_DEFAULT;
    end else if (restore_ev) begin
      div_reg  <= scm_pkg::DIV_DEFAULT;
      esc_reg  <= scm_pkg::ESC_DEFAULT;
      mode_reg <= scm_pkg::command_driven_link_mode;
      role_reg <= scm_pkg::ROLE_DEFAULT;
    end else begin
      if (wr_div && wdata_i[15:0] > 16'h0001) begin
        div_reg <= wdata_i[15:0];   // tiny divisors would stall the receiver
      end
      if (wr_link) begin
        esc_reg  <= wdata_i[scm_pkg::LINK_ESC_LSB +: 8];
        mode_reg <= wdata_i[scm_pkg::LINK_MODE_LSB +: 3];
        role_reg <= wdata_i[scm_pkg::LINK_ROLE_BIT];
      end
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_o        <= 1'b0;
      rdata_o      <= 32'h0000_0000;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_ist ? wdata_i[scm_pkg::IRQ_W-1:0] : '0))
                      | irq_events;
      if (wr_imsk) begin
        irq_mask_reg <= wdata_i[scm_pkg::IRQ_W-1:0];
      end
      irq_o   <= |(irq_stat_reg & irq_mask_reg);
      rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
    end
  end
endmodule

// [logic/scm_pkg.sv]
package scm_pkg;
  // clocking and serial line
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned BAUD_DEFAULT    = 9600;
  localparam logic [15:0] DIV_DEFAULT     = 16'(CLK_HZ / BAUD_DEFAULT);
  // factory restore hold time
  localparam int unsigned RESTORE_TIME_MS = 2000;
  localparam int unsigned RESTORE_CYCLES  = CLK_HZ / 1000 * RESTORE_TIME_MS;

  // connection modes, the command driven one is the factory choice
  typedef enum logic [2:0] {
    SCM_MODE0                = 3'h0,
    SCM_MODE1                = 3'h1,
    SCM_MODE2                = 3'h2,
    SCM_MODE3                = 3'h3,
    command_driven_link_mode = 3'h4
  } scm_conn_mode_t;

  // factory values
  localparam logic [7:0] ESC_DEFAULT  = 8'h02;
  localparam logic       ROLE_DEFAULT = 1'b0;   // 0 = slave

  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_UART_DIV = 8'h00;
  localparam logic [7:0] ADDR_LINK_CFG = 8'h04;
  localparam logic [7:0] ADDR_MENU_ST  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ST   = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // link config fields
  localparam int unsigned LINK_ESC_LSB  = 0;
  localparam int unsigned LINK_MODE_LSB = 8;
  localparam int unsigned LINK_ROLE_BIT = 12;
  // menu status fields
  localparam int unsigned MST_ACT_BIT   = 0;
  localparam int unsigned MST_CNT_LSB   = 4;
  localparam int unsigned MST_SEL_LSB   = 8;

  // interrupt status bits
  localparam int unsigned IRQ_SEL     = 0;
  localparam int unsigned IRQ_RETRY   = 1;
  localparam int unsigned IRQ_OVF     = 2;
  localparam int unsigned IRQ_RESTORE = 3;
  localparam int unsigned IRQ_W       = 4;

  // characters of the line discipline
  localparam logic [7:0] CH_CR   = 8'h0D;
  localparam logic [7:0] CH_LF   = 8'h0A;
  localparam logic [7:0] CH_BS   = 8'h08;
  localparam logic [7:0] CH_DEL  = 8'h7F;
  localparam logic [7:0] CH_TOP  = 8'h74;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_LAST = 8'h36;
  localparam logic [3:0] LINE_MAX = 4'hC;

  // message rom layout: overflow runs into retry, banner runs into prompt
  localparam int unsigned MSG_LEN       = 59;
  localparam logic [5:0]  MSG_OVF       = 6'h00;
  localparam logic [5:0]  MSG_RETRY     = 6'h11;
  localparam logic [5:0]  MSG_RETRY_END = 6'h17;
  localparam logic [5:0]  MSG_TOP       = 6'h18;
  localparam logic [5:0]  MSG_PROMPT    = 6'h2C;
  localparam logic [5:0]  MSG_END       = 6'h3A;

  // menu states, gray along off -> send -> wait
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b11
  } scm_state_t;
endpackage

// [logic/scm_uart.sv]
`timescale 1ns/1ps
module scm_uart (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [15:0] div_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic            tx_o,
  input  wire logic       rx_i,
  output logic [7:0]      rx_data_o,
  output logic            rx_valid_o
);
  logic [8:0]  tx_shift_reg;
  logic [3:0]  tx_bits_reg;
  logic [15:0] tx_cnt_reg;
  logic        rx_busy_reg;
  logic [3:0]  rx_bit_reg;
  logic [15:0] rx_cnt_reg;
  logic [15:0] div_m1;

  assign div_m1     = div_i - 16'h0001;
  assign tx_ready_o = (tx_bits_reg == 4'h0);

  // transmitter: start, eight data lsb first, one stop
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_o         <= 1'b1;
      tx_shift_reg <= 9'h1FF;
      tx_bits_reg  <= 4'h0;
      tx_cnt_reg   <= 16'h0000;
    end else if (tx_ready_o && tx_valid_i) begin
      tx_o         <= 1'b0;
      tx_shift_reg <= {1'b1, tx_data_i};
      tx_bits_reg  <= 4'hA;
      tx_cnt_reg   <= div_m1;
    end else if (tx_bits_reg != 4'h0) begin
      if (tx_cnt_reg == 16'h0000) begin
        tx_o         <= tx_shift_reg[0];
        tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
        tx_bits_reg  <= tx_bits_reg - 4'h1;
        tx_cnt_reg   <= div_m1;
      end else begin
        tx_cnt_reg <= tx_cnt_reg - 16'h0001;
      end
    end
  end

  // receiver samples mid bit; a start glitch shorter than half a bit is dropped
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_busy_reg <= 1'b0;
      rx_bit_reg  <= 4'h0;
      rx_cnt_reg  <= 16'h0000;
      rx_data_o   <= 8'h00;
      rx_valid_o  <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (!rx_busy_reg) begin
        if (!rx_i) begin
          rx_busy_reg <= 1'b1;
          rx_bit_reg  <= 4'h0;
          rx_cnt_reg  <= {1'b0, div_i[15:1]};
        end
      end else if (rx_cnt_reg != 16'h0000) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end else begin
        rx_cnt_reg <= div_m1;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0) begin
          rx_busy_reg <= !rx_i;
        end else if (rx_bit_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          rx_valid_o  <= rx_i;  // framing error drops the byte
        end else begin
          rx_data_o <= {rx_i, rx_data_o[7:1]};
        end
      end
    end
  end
endmodule

// [testbench/scm_menu_chk.sv]
`timescale 1ns/1ps
// port-level watcher of the menu block
module scm_menu_chk #(
  parameter int unsigned RESTORE_CYCLES = scm_pkg::RESTORE_CYCLES
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        irq_o,
  input wire logic        factory_restore_n_i,
  input wire logic        rxd_i,
  input wire logic        txd_o,
  input wire logic        menu_active_o
);
  localparam logic [31:0] DEF = {19'h0, scm_pkg::ROLE_DEFAULT, 1'b0,
    scm_pkg::command_driven_link_mode, scm_pkg::ESC_DEFAULT};
  logic        seen_reg;
  logic        div_reg;
  logic        cfg_reg;
  logic        mz_reg;
  int unsigned low_reg;
  // restore fires on the RESTORE_CYCLES-th low cycle while still held; it saturates so one press fires once
  wire logic hit = !factory_restore_n_i && low_reg == RESTORE_CYCLES - 1;
  wire logic wdv = wr_i && addr_i == scm_pkg::ADDR_UART_DIV && wdata_i[15:0] > 16'h0001;
  wire logic wcf = wr_i && addr_i == scm_pkg::ADDR_LINK_CFG;
  wire logic wmk = wr_i && addr_i == scm_pkg::ADDR_IRQ_MASK;
  wire logic rms = rd_i && addr_i == scm_pkg::ADDR_MENU_ST;
  // settings touched since reset or restore; restore wins a tie
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_reg <= 1'b0;
      div_reg  <= 1'b0;
      cfg_reg  <= 1'b0;
      mz_reg   <= 1'b1;
      low_reg  <= 0;
    end else begin
      seen_reg <= 1'b1;
      div_reg  <= !hit && (div_reg || wdv);
      cfg_reg  <= !hit && (cfg_reg || wcf);
      mz_reg   <= wmk ? wdata_i[3:0] == 4'h0 : mz_reg;
      low_reg  <= factory_restore_n_i ? 0 : low_reg + 32'(low_reg < RESTORE_CYCLES);
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_held; menu_active_o |=> menu_active_o; endproperty
  a_held: assert property (p_held) else $error("menu dropped");
  property p_entry; !seen_reg |=> menu_active_o == !$past(factory_restore_n_i); endproperty
  a_entry: assert property (p_entry) else $error("power-up entry wrong");
  property p_late; seen_reg && !menu_active_o |=> !menu_active_o; endproperty
  a_late: assert property (p_late) else $error("menu entered late");
  property p_div; rd_i && addr_i == scm_pkg::ADDR_UART_DIV && !div_reg
    |=> rdata_o == {16'h0, scm_pkg::DIV_DEFAULT}; endproperty
  a_div: assert property (p_div) else $error("divisor not default");
  property p_cfg; rd_i && addr_i == scm_pkg::ADDR_LINK_CFG && !cfg_reg |=> rdata_o == DEF;
  endproperty
  a_cfg: assert property (p_cfg) else $error("link config not default");
  property p_idle; !rd_i |=> rdata_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
  property p_cnt; rms |=> rdata_o[7:4] <= scm_pkg::LINE_MAX; endproperty
  a_cnt: assert property (p_cnt) else $error("line count too big");
  property p_act; rms |=> rdata_o[0] == $past(menu_active_o); endproperty
  a_act: assert property (p_act) else $error("status bit differs");
  property p_mask; mz_reg && $past(mz_reg) |-> !irq_o; endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt seen");
  c_entry: cover property (!seen_reg && !factory_restore_n_i);
  c_hit: cover property (hit);
  c_irq: cover property ($rose(irq_o));
endmodule

bind scm_menu scm_menu_chk #(.RESTORE_CYCLES(RESTORE_CYCLES)) scm_menu_chk_inst (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .factory_restore_n_i(factory_restore_n_i), .rxd_i(rxd_i), .txd_o(txd_o),
  .menu_active_o(menu_active_o));

// [testbench/scm_host_model.sv]
`timescale 1ns/1ps
// host terminal, 8N1, line idles high
module scm_host_model (
  input  wire logic ref_clk_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  int         bit_cycles = 16;
  int         prompt_cnt = 0;
  logic [7:0] rx_byte;
  initial rxd_o = 1'b1;
  // one whole frame per call; the bench ends an entry with Enter, with 't' or with a thirteenth character
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk_i);
      rxd_o <= frame[i];
      repeat (bit_cycles - 1) @(posedge ref_clk_i);
    end
  endtask
  // counts prompts; slow or bad frames fail the stop bit and are dropped
  always begin
    @(posedge ref_clk_i);
    if (txd_i === 1'b0) begin
      repeat (bit_cycles / 2) @(posedge ref_clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cycles) @(posedge ref_clk_i);
        rx_byte[i] = txd_i;
      end
      repeat (bit_cycles) @(posedge ref_clk_i);
      if (txd_i === 1'b1 && rx_byte === 8'h3E) prompt_cnt++;
      while (txd_i !== 1'b1) @(posedge ref_clk_i);
    end
  end
endmodule

// [testbench/serial_config_menu_bench.sv]
`timescale 1ns/1ps
module serial_config_menu_bench;
  localparam int          RC  = 200;
  localparam logic [7:0]  DV  = scm_pkg::ADDR_UART_DIV;
  localparam logic [7:0]  CF  = scm_pkg::ADDR_LINK_CFG;
  localparam logic [7:0]  MS  = scm_pkg::ADDR_MENU_ST;
  localparam logic [7:0]  IS  = scm_pkg::ADDR_IRQ_ST;
  localparam logic [7:0]  CR  = scm_pkg::CH_CR;
  localparam logic [31:0] DEF = {19'h0, scm_pkg::ROLE_DEFAULT, 1'b0,
    scm_pkg::command_driven_link_mode, scm_pkg::ESC_DEFAULT};
  logic        ref_clk_i;
  logic        rst_n_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        irq_o;
  logic        factory_restore_n_i;
  logic        rxd_i;
  logic        txd_o;
  logic        menu_active_o;
  logic [31:0] seed;
  logic [31:0] msk;
  logic [2:0]  sel;
  int          errors;
  int          comparisons;
  int          d;

  scm_menu #(.RESTORE_CYCLES(RC)) scm_menu_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .factory_restore_n_i(factory_restore_n_i), .rxd_i(rxd_i),
    .txd_o(txd_o), .menu_active_o(menu_active_o));
  scm_host_model scm_host_model_inst (.ref_clk_i(ref_clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected status word with the menu shown
  function logic [31:0] mst(input logic [3:0] cnt, input logic [2:0] s);
    return {21'h0, s, cnt, 4'h1};
  endfunction

  task check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task tally_and_finish;
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // bus cycles: strobe for one cycle, read data only in the next
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] want);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o & msk, want);
  endtask
  task irqc(input logic [31:0] want);
    repeat (2) @(posedge ref_clk_i);
    #1 check(irq_o, want);
  endtask
  task send(input logic [7:0] b);
    scm_host_model_inst.send_byte(b);
  endtask
  // send a key (none if zero) and wait, bounded, for exactly one prompt
  task reply(input logic [7:0] b, input int lim);
    int n;
    n = scm_host_model_inst.prompt_cnt;
    if (b != 8'h00) send(b);
    for (int i = 0; i < lim && scm_host_model_inst.prompt_cnt == n; i++) @(posedge ref_clk_i);
    check(scm_host_model_inst.prompt_cnt - n, 32'h1);
  endtask
  task hold(input int n);
    @(posedge ref_clk_i);
    factory_restore_n_i <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
    factory_restore_n_i <= 1'b1;
  endtask

  // watchdog: about twice the expected run at sixteen clocks per bit
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    errors++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h0001_6764;
    msk = 32'hFFFF_FFFF;
    sel = 3'h0;
    errors = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    factory_restore_n_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    // divisor lands on edge 1, so the strap banner already runs at the fast rate
    rst_n_i <= 1'b1;
    addr_i  <= DV;
    wdata_i <= 32'h0000_0010;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i                <= 1'b0;
    factory_restore_n_i <= 1'b1;
    wr(scm_pkg::ADDR_IRQ_MASK, 32'h0000_000F);
    rdc(CF, DEF);
    rdc(8'h20, 32'h0);
    rdc(MS, mst(4'h0, sel));
    reply(8'h00, 8000);
    d = int'(rnd() % 7);
    for (int k = 0; k < 7; k++) begin
      d = (d + 1) % 7;
      send(scm_pkg::CH_ZERO + 8'(d));
      rdc(MS, mst(4'h1, sel));
      reply(CR, 8000);
      sel = 3'(d);
      rdc(MS, mst(4'h0, sel));
      rdc(IS, 32'h1 << scm_pkg::IRQ_SEL);
      irqc(32'h1);
      wr(IS, 32'h0000_000F);
      irqc(32'h0);
    end
    send(scm_pkg::CH_BS);
    send(8'h39);
    send(rnd() % 2 ? scm_pkg::CH_BS : scm_pkg::CH_DEL);
    send(8'h32);
    rdc(MS, mst(4'h1, sel));
    reply(CR, 8000);
    sel = 3'h2;
    rdc(MS, mst(4'h0, sel));
    wr(IS, 32'h0000_000F);
    for (int k = 0; k < 2; k++) begin
      send(k == 0 ? scm_pkg::CH_LAST + 8'h01 : 8'h61 + 8'(rnd() % 19));
      reply(CR, 8000);
      rdc(IS, 32'h1 << scm_pkg::IRQ_RETRY);
      rdc(MS, mst(4'h0, sel));
      wr(IS, 32'h0000_000F);
    end
    for (int k = 0; k < 12; k++) send(8'h30 + 8'(rnd() % 10));
    rdc(MS, mst(scm_pkg::LINE_MAX, sel));
    rdc(IS, 32'h0);
    reply(8'h35, 8000);
    msk = 32'h1 << scm_pkg::IRQ_OVF;
    rdc(IS, msk);
    msk = 32'hFFFF_FFFF;
    rdc(MS, mst(4'h0, sel));
    wr(IS, 32'h0000_000F);
    send(8'h34);
    reply(scm_pkg::CH_TOP, 8000);
    rdc(MS, mst(4'h0, sel));
    rdc(IS, 32'h0);
    wr(CF, 32'h0000_1155);
    hold(RC - 5);
    rdc(CF, 32'h0000_1155);
    rdc(IS, 32'h0);
    @(posedge ref_clk_i);
    factory_restore_n_i <= 1'b0;
    repeat (RC + 20) @(posedge ref_clk_i);
    rdc(IS, 32'h1 << scm_pkg::IRQ_RESTORE);
    wr(IS, 32'h0000_000F);
    repeat (RC) @(posedge ref_clk_i);
    factory_restore_n_i <= 1'b1;
    rdc(IS, 32'h0);
    rdc(CF, DEF);
    rdc(DV, {16'h0, scm_pkg::DIV_DEFAULT});
    rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rdc(MS, 32'h0);
    rdc(DV, {16'h0, scm_pkg::DIV_DEFAULT});
    wr(CF, 32'h0000_1155);
    hold(RC + 10);
    rdc(IS, 32'h1 << scm_pkg::IRQ_RESTORE);
    irqc(32'h0);
    rdc(CF, DEF);
    wr(scm_pkg::ADDR_IRQ_MASK, 32'h0000_0008);
    irqc(32'h1);
    wr(IS, 32'h0000_0008);
    irqc(32'h0);
    tally_and_finish();
  end
endmodule
